// *** rtl/synth_cfg_top.sv ***
// configuration and clock control of a pll frequency synthesizer
// assumes the configuration pins are asynchronous to I_CLOCK and the apb pins are not; the analog pll is outside
// and I_CLOCK stands in for four ticks of one vco period

module synth_cfg_top (
	input wire logic I_CLOCK, // system clock, 50 MHz
	input wire logic I_RST, // asynchronous reset, active high
	input wire logic I_MASTER_RESET_IN, // divider reset pin
	input wire logic I_PARALLEL_LOAD_STROBE_N, // parallel load strobe
	input wire logic I_SERIAL_CLOCK, // serial shift clock pin
	input wire logic I_SERIAL_DATA, // serial data pin
	input wire logic I_SERIAL_LOAD, // serial load strobe pin
	input wire logic [8:0] I_FEEDBACK_DIVIDE_BITS, // parallel feedback
	input wire logic [2:0] I_OUTPUT_DIVIDE_CODE, // parallel out code
	input wire logic I_REFERENCE_SOURCE_SELECT, // 1 crystal, 0 alt
	input wire logic I_PLL_BYPASS_SELECT, // 1 pll, 0 bypass
	input wire logic I_CRYSTAL_OSC_INPUT, // crystal oscillator input
	input wire logic I_ALT_REF_CLOCK, // alternate reference clock
	output logic O_CRYSTAL_OSC_OUTPUT, // oscillator feedback drive
	output logic [1:0] O_CLOCK_OUT_TRUE, // true clock outputs
	output logic [1:0] O_CLOCK_OUT_COMPLEMENT, // complement outputs
	output logic O_MONITOR, // monitor output
	output logic O_PFD_REF, // divided reference to phase detector
	output logic O_FB_DIV_OUT, // feedback divider to phase detector
	input wire logic I_PSEL, // apb select
	input wire logic I_PENABLE, // apb enable
	input wire logic I_PWRITE, // apb direction
	input wire logic [11:0] I_PADDR, // apb byte address
	input wire logic [31:0] I_PWDATA, // apb write data
	output logic [31:0] O_PRDATA, // apb read data
	output logic O_PREADY, // apb ready
	output logic O_PSLVERR // apb error
);
	logic [synth_pkg::PIN_CNT-1:0] pin_raw;
	logic [synth_pkg::PIN_CNT-1:0] s1_r;
	logic [synth_pkg::PIN_CNT-1:0] s2_r;
	logic [synth_pkg::PIN_CNT-1:0] s3_r;
	logic [synth_pkg::PIN_CNT-1:0] filt_r;
	logic [synth_pkg::PIN_CNT-1:0] prev_r;
	logic [synth_pkg::PIN_CNT-1:0] rise;
	logic [synth_pkg::PIN_CNT-1:0] fall;
	logic sclk;
	logic sdata;
	logic sload;
	logic sclk_rise;
	logic sload_rise;
	logic sload_fall;
	logic pload_rise;
	logic [8:0] pin_m;
	logic [2:0] pin_n;
	synth_pkg::load_mode_type mode;
	logic [13:0] shift_r;
	logic [13:0] shift_in;
	logic [8:0] m_r;
	logic [2:0] n_r;
	logic [1:0] t_r;
	logic [8:0] m_eff;
	logic [2:0] n_eff;
	logic soft_rst_r;
	logic hold;
	logic ref_lvl;
	logic ref_rise;
	logic ref_edge;
	logic pll_mode;
	logic [2:0] pre_cnt_r;
	logic pfd_r;
	logic [9:0] fb_cnt_r;
	logic [9:0] fb_cnt_nxt;
	logic [9:0] fb_half;
	logic fb_r;
	logic mon_nxt;
	logic mon_r;
	logic [1:0] true_r;
	logic [1:0] comp_r;
	logic crystal_osc_output_r;
	logic apb_setup;
	logic apb_access;
	logic addr_ok;
	logic [31:0] rd_nxt;
	logic [31:0] prdata_r;
	div_if dv();

	assign pin_raw = {I_OUTPUT_DIVIDE_CODE, I_FEEDBACK_DIVIDE_BITS,
		I_ALT_REF_CLOCK, I_CRYSTAL_OSC_INPUT, I_PLL_BYPASS_SELECT,
		I_REFERENCE_SOURCE_SELECT, I_MASTER_RESET_IN,
		I_PARALLEL_LOAD_STROBE_N, I_SERIAL_LOAD, I_SERIAL_DATA,
		I_SERIAL_CLOCK};

	// three-stage sampler per pin; a level counts once stages two and
	// three agree, which also rejects a single-cycle glitch
	generate
		for (genvar i = 0; i < synth_pkg::PIN_CNT; i++) begin : g_pin
			always_ff @(posedge I_CLOCK or posedge I_RST) begin
				if (I_RST) begin
					s1_r[i] <= 1'b0;
					s2_r[i] <= 1'b0;
					s3_r[i] <= 1'b0;
					filt_r[i] <= 1'b0;
					prev_r[i] <= 1'b0;
				end else begin
					s1_r[i] <= pin_raw[i];
					s2_r[i] <= s1_r[i];
					s3_r[i] <= s2_r[i];
					if (s2_r[i] == s3_r[i]) begin
						filt_r[i] <= s3_r[i];
					end
					prev_r[i] <= filt_r[i];
				end
			end
			assign rise[i] = filt_r[i] & ~prev_r[i];
			assign fall[i] = ~filt_r[i] & prev_r[i];
		end
	endgenerate

	assign sclk = filt_r[synth_pkg::PIN_SCLK];
	assign sdata = filt_r[synth_pkg::PIN_SDATA];
	assign sload = filt_r[synth_pkg::PIN_SLOAD];
	assign sclk_rise = rise[synth_pkg::PIN_SCLK];
	assign sload_rise = rise[synth_pkg::PIN_SLOAD];
	assign sload_fall = fall[synth_pkg::PIN_SLOAD];
	assign pload_rise = rise[synth_pkg::PIN_PLOAD];
	assign pin_m = filt_r[synth_pkg::PIN_M_LSB +: synth_pkg::M_W];
	assign pin_n = filt_r[synth_pkg::PIN_N_LSB +: synth_pkg::N_W];
	assign mode = filt_r[synth_pkg::PIN_PLOAD] ?
		synth_pkg::MODE_SERIAL : synth_pkg::MODE_PARALLEL;

	// first bit in ends at the top, so the frame lands msb first
	assign shift_in = {shift_r[synth_pkg::FRAME_W-2:0], sdata};

	// shift register moves only on serial clock, never on parallel pins
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			shift_r <= 14'h0000;
		end else if (mode == synth_pkg::MODE_SERIAL && sclk_rise) begin
			shift_r <= shift_in;
		end
	end

	// loaded values; master reset is deliberately absent here
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			m_r <= synth_pkg::M_RST;
			n_r <= synth_pkg::N_RST;
			t_r <= synth_pkg::T_RST;
		end else if (pload_rise && !sload) begin
			m_r <= pin_m;
			n_r <= pin_n;
		end else if (mode == synth_pkg::MODE_SERIAL) begin
			if (sload_rise && !sclk) begin
				m_r <= shift_r[synth_pkg::FLD_M_LSB +: synth_pkg::M_W];
				n_r <= shift_r[synth_pkg::FLD_N_LSB +: synth_pkg::N_W];
				t_r <= shift_r[synth_pkg::FLD_T_LSB +: synth_pkg::T_W];
			end else if (sload && sclk_rise) begin
				m_r <= shift_in[synth_pkg::FLD_M_LSB +: synth_pkg::M_W];
				n_r <= shift_in[synth_pkg::FLD_N_LSB +: synth_pkg::N_W];
				t_r <= shift_in[synth_pkg::FLD_T_LSB +: synth_pkg::T_W];
			end
			// a falling serial strobe simply leaves the values held
		end
	end

	// parallel mode passes the pins straight to the dividers
	assign m_eff = (mode == synth_pkg::MODE_PARALLEL) ? pin_m : m_r;
	assign n_eff = (mode == synth_pkg::MODE_PARALLEL) ? pin_n : n_r;

	// pin reset or software reset; both stop dividers only
	assign hold = filt_r[synth_pkg::PIN_MR] | soft_rst_r;

	// reference choice
	assign ref_lvl = filt_r[synth_pkg::PIN_REFSEL] ?
		filt_r[synth_pkg::PIN_XTAL] : filt_r[synth_pkg::PIN_ALTREF];
	assign ref_rise = filt_r[synth_pkg::PIN_REFSEL] ?
		rise[synth_pkg::PIN_XTAL] : rise[synth_pkg::PIN_ALTREF];
	assign ref_edge = ref_rise | (filt_r[synth_pkg::PIN_REFSEL] ?
		fall[synth_pkg::PIN_XTAL] : fall[synth_pkg::PIN_ALTREF]);
	assign pll_mode = filt_r[synth_pkg::PIN_BYPASS];

	// divide by 16 ahead of the phase detector
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			pre_cnt_r <= 3'h0;
			pfd_r <= 1'b0;
		end else if (hold) begin
			pre_cnt_r <= 3'h0;
			pfd_r <= 1'b0;
		end else if (ref_rise) begin
			if (pre_cnt_r == synth_pkg::PREDIV_LAST) begin
				pre_cnt_r <= 3'h0;
				pfd_r <= ~pfd_r;
			end else begin
				pre_cnt_r <= pre_cnt_r + 3'h1;
			end
		end
	end

	// feedback divider: ratio is the plain binary value
	// half period of m vco periods is m*4/2 ticks
	assign fb_half = {m_eff, 1'b0};
	assign fb_cnt_nxt = fb_cnt_r + 10'h001;

	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			fb_cnt_r <= 10'h000;
			fb_r <= 1'b0;
		end else if (hold) begin
			fb_cnt_r <= 10'h000;
			fb_r <= 1'b0;
		end else if (fb_cnt_nxt >= fb_half) begin
			fb_cnt_r <= 10'h000;
			fb_r <= ~fb_r;
		end else begin
			fb_cnt_r <= fb_cnt_nxt;
		end
	end

	// pll mode ticks every clock; bypass ticks on reference edges
	assign dv.tick = pll_mode ? 1'b1 : ref_edge;
	assign dv.hold = hold;
	assign dv.code = n_eff;

	out_divider u_out_div (
		.i_clk(I_CLOCK),
		.i_rst(I_RST),
		.d(dv.div)
	);

	// registered differential pairs forced apart during reset
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			true_r <= 2'h0;
			comp_r <= 2'h3;
		end else if (hold) begin
			true_r <= 2'h0;
			comp_r <= 2'h3;
		end else begin
			true_r <= {2{dv.out}};
			comp_r <= {2{~dv.out}};
		end
	end

	// monitor selection; parallel mode always drives low
	always_comb begin
		case (synth_pkg::monitor_sel_type'(t_r))
			synth_pkg::MON_LOW: mon_nxt = 1'b0;
			synth_pkg::MON_SDATA: mon_nxt = sdata;
			synth_pkg::MON_FB: mon_nxt = fb_r;
			synth_pkg::MON_CLK: mon_nxt = dv.out;
			default: mon_nxt = 1'b0;
		endcase
		if (mode == synth_pkg::MODE_PARALLEL) begin
			mon_nxt = 1'b0;
		end
	end

	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			mon_r <= 1'b0;
		end else begin
			mon_r <= mon_nxt;
		end
	end

	// inverting oscillator drive; only a logic model of the amplifier
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			crystal_osc_output_r <= 1'b0;
		end else begin
			crystal_osc_output_r <= ~filt_r[synth_pkg::PIN_XTAL];
		end
	end

	// apb slave: zero wait states; read data captured in the setup cycle
	assign apb_setup = I_PSEL & ~I_PENABLE;
	assign apb_access = I_PSEL & I_PENABLE;
	assign addr_ok = (I_PADDR == synth_pkg::CTRL_ADDR) |
		(I_PADDR == synth_pkg::STATUS_ADDR) |
		(I_PADDR == synth_pkg::SHIFT_ADDR);

	always_comb begin
		rd_nxt = 32'h00000000;
		case (I_PADDR)
			synth_pkg::CTRL_ADDR: begin
				rd_nxt[synth_pkg::CTRL_SOFT_RST_BIT] = soft_rst_r;
			end
			synth_pkg::STATUS_ADDR: begin
				rd_nxt[synth_pkg::ST_M_LSB +: synth_pkg::M_W] = m_eff;
				rd_nxt[synth_pkg::ST_N_LSB +: synth_pkg::N_W] = n_eff;
				rd_nxt[synth_pkg::ST_T_LSB +: synth_pkg::T_W] = t_r;
				rd_nxt[synth_pkg::ST_MODE_BIT] = mode;
				rd_nxt[synth_pkg::ST_RUN_BIT] = ~hold;
				rd_nxt[synth_pkg::ST_PLL_BIT] = pll_mode;
				rd_nxt[synth_pkg::ST_REF_BIT] = ref_lvl;
			end
			synth_pkg::SHIFT_ADDR: begin
				rd_nxt[synth_pkg::FRAME_W-1:0] = shift_r;
			end
			default: rd_nxt = 32'h00000000;
		endcase
	end

	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			prdata_r <= 32'h00000000;
		end else if (apb_setup) begin
			prdata_r <= rd_nxt;
		end
	end

	// software reset of the dividers; loaded values are untouched
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			soft_rst_r <= 1'b0;
		end else if (apb_access && I_PWRITE &&
			I_PADDR == synth_pkg::CTRL_ADDR) begin
			soft_rst_r <= I_PWDATA[synth_pkg::CTRL_SOFT_RST_BIT];
		end
	end

	assign O_PRDATA = prdata_r;
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = apb_access & ~addr_ok;
	assign O_CLOCK_OUT_TRUE = true_r;
	assign O_CLOCK_OUT_COMPLEMENT = comp_r;
	assign O_MONITOR = mon_r;
	assign O_PFD_REF = pfd_r;
	assign O_FB_DIV_OUT = fb_r;
	assign O_CRYSTAL_OSC_OUTPUT = crystal_osc_output_r;
endmodule : synth_cfg_top

// *** shared/synth_pkg.sv ***
// constants and types of the synthesizer configuration logic
// assumes one 50 MHz system clock; pins are sampled, never used as clocks
package synth_pkg;
	localparam int CLK_HZ = 50000000;
	localparam int M_W = 9;
	localparam int N_W = 3;
	localparam int T_W = 2;
	localparam int FRAME_W = 14;
	localparam int FLD_M_LSB = 0;
	localparam int FLD_N_LSB = 9;
	localparam int FLD_T_LSB = 12;
	localparam logic [8:0] M_RST = 9'h0FA;
	localparam logic [2:0] N_RST = 3'h0;
	localparam logic [1:0] T_RST = 2'h0;
	localparam int PREDIV_RATIO = 16;
	localparam int PREDIV_W = 3;
	localparam logic [2:0] PREDIV_LAST = 3'(PREDIV_RATIO / 2 - 1);
	// the system clock stands in for a quarter of a vco period
	localparam int TICKS_PER_VCO = 4;
	localparam int FB_W = 10;
	localparam int HALF_W = 5;
	// half periods in ticks per code: 0.5,0.75,1,1.5,2,3,4,6 vco periods
	localparam logic [7:0][4:0] HALF_TICKS = {5'h18, 5'h10, 5'h0C,
		5'h08, 5'h06, 5'h04, 5'h03, 5'h02};
	localparam int PIN_SCLK = 0;
	localparam int PIN_SDATA = 1;
	localparam int PIN_SLOAD = 2;
	localparam int PIN_PLOAD = 3;
	localparam int PIN_MR = 4;
	localparam int PIN_REFSEL = 5;
	localparam int PIN_BYPASS = 6;
	localparam int PIN_XTAL = 7;
	localparam int PIN_ALTREF = 8;
	localparam int PIN_M_LSB = 9;
	localparam int PIN_N_LSB = 18;
	localparam int PIN_CNT = 21;
	localparam int ADDR_W = 12;
	localparam logic [11:0] CTRL_ADDR = 12'h000;
	localparam logic [11:0] STATUS_ADDR = 12'h004;
	localparam logic [11:0] SHIFT_ADDR = 12'h008;
	localparam int CTRL_SOFT_RST_BIT = 0;
	localparam int ST_M_LSB = 0;
	localparam int ST_N_LSB = 9;
	localparam int ST_T_LSB = 12;
	localparam int ST_MODE_BIT = 16;
	localparam int ST_RUN_BIT = 17;
	localparam int ST_PLL_BIT = 18;
	localparam int ST_REF_BIT = 19;
	typedef enum logic [1:0] {
		MON_LOW = 2'b00,
		MON_SDATA = 2'b01,
		MON_FB = 2'b10,
		MON_CLK = 2'b11
	} monitor_sel_type;
	typedef enum logic {
		MODE_PARALLEL = 1'b0,
		MODE_SERIAL = 1'b1
	} load_mode_type;
endpackage : synth_pkg

// *** shared/div_if.sv ***
// carrier between the configuration logic and the output divider
// assumes both ends sit in the system clock domain
interface div_if;
	logic tick;
	logic hold;
	logic [2:0] code;
	logic out;
	modport ctl(output tick, output hold, output code, input out);
	modport div(input tick, input hold, input code, output out);
endinterface : div_if

// *** rtl/out_divider.sv ***
// output divider: 50% duty square wave from a tick stream
// assumes tick, hold and code come from the system clock domain
module out_divider (
	input wire logic i_clk, // system clock
	input wire logic i_rst, // asynchronous reset, active high
	div_if.div d // tick, ratio code, hold and divided output
);
	logic [4:0] cnt_r;
	logic [4:0] cnt_nxt;
	logic [4:0] half;
	logic out_r;

	assign half = synth_pkg::HALF_TICKS[d.code];
	assign cnt_nxt = cnt_r + 5'h01;
	assign d.out = out_r;

	// counting half periods in ticks keeps ratio 1.5 at 50% duty
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_r <= 5'h00;
			out_r <= 1'b0;
		end else if (d.hold) begin
			cnt_r <= 5'h00;
			out_r <= 1'b0;
		end else if (d.tick) begin
			// >= so a code change mid-count cannot strand the counter
			if (cnt_nxt >= half) begin
				cnt_r <= 5'h00;
				out_r <= ~out_r;
			end else begin
				cnt_r <= cnt_nxt;
			end
		end
	end
endmodule : out_divider

// *** sim/synth_cfg_props.sv ***
// concurrent checks on the synthesizer configuration block
// assumes it is bound to synth_cfg_top and sees its ports only
module synth_cfg_props (
	input wire logic I_CLOCK, // system clock
	input wire logic I_RST, // async reset
	input wire logic I_MASTER_RESET_IN, // divider reset pin
	input wire logic I_PARALLEL_LOAD_STROBE_N, // parallel strobe
	input wire logic I_PLL_BYPASS_SELECT, // 1 pll
	input wire logic I_PSEL, // apb select
	input wire logic I_PENABLE, // apb enable
	input wire logic [11:0] I_PADDR, // apb address
	input wire logic [1:0] O_CLOCK_OUT_TRUE, // true outputs
	input wire logic [1:0] O_CLOCK_OUT_COMPLEMENT, // complements
	input wire logic O_MONITOR, // monitor
	input wire logic O_PFD_REF, // divided reference
	input wire logic [31:0] O_PRDATA, // read data
	input wire logic O_PREADY, // ready
	input wire logic O_PSLVERR // error
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (I_RST);
	logic mapped;
	assign mapped = I_PADDR inside {12'h000, 12'h004, 12'h008};
	a_mr_holds_low: assert property (
		I_MASTER_RESET_IN [*8] |->
		O_CLOCK_OUT_TRUE == 2'h0 && O_CLOCK_OUT_COMPLEMENT == 2'h3)
		else $error("outputs not held in reset");
	a_outs_inverse: assert property (
		O_CLOCK_OUT_COMPLEMENT == ~O_CLOCK_OUT_TRUE)
		else $error("complement output not inverse");
	a_outs_pair: assert property (
		O_CLOCK_OUT_TRUE[0] == O_CLOCK_OUT_TRUE[1])
		else $error("true outputs differ");
	// release must restart the divider within a few half periods
	a_mr_release_runs: assert property (
		$fell(I_MASTER_RESET_IN) && I_PLL_BYPASS_SELECT |->
		##[8:80] $changed(O_CLOCK_OUT_TRUE))
		else $error("divider idle after reset release");
	a_par_mon_low: assert property (
		!I_PARALLEL_LOAD_STROBE_N [*8] |-> !O_MONITOR)
		else $error("monitor active in parallel mode");
	a_pfd_slow: assert property (
		$changed(O_PFD_REF) |=> $stable(O_PFD_REF) [*8])
		else $error("phase reference toggles too fast");
	a_unmapped_err: assert property (
		I_PSEL && I_PENABLE && !mapped |->
		O_PSLVERR && O_PRDATA == 32'h0)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (
		I_PSEL && I_PENABLE && mapped |-> O_PREADY && !O_PSLVERR)
		else $error("mapped access refused");
endmodule : synth_cfg_props

// *** sim/synth_ctl_model.sv ***
// external controller driving the three serial load pins
// assumes i_clk is the bench clock; pins move just after its edges
module synth_ctl_model (
	input wire logic i_clk, // bench clock
	output logic o_sclk, // serial clock pin
	output logic o_sdata, // serial data pin
	output logic o_sload // serial load pin
);
	timeunit 1ns;
	timeprecision 1ps;
	int gap = 4; // clocks per level; raised for a slow controller
	initial begin
		o_sclk = 0;
		o_sdata = 0;
		o_sload = 0;
	end
	task automatic level(input logic b);
		o_sdata <= b;
		repeat (gap) @(posedge i_clk);
	endtask : level
	// data settles a whole gap before the clock rises
	task automatic shift(input logic b);
		level(b);
		o_sclk <= 1;
		repeat (gap) @(posedge i_clk);
		o_sclk <= 0;
		repeat (gap) @(posedge i_clk);
	endtask : shift
	// monitor bits first, then each field msb first
	task automatic send(input logic [13:0] f);
		for (int i = 13; i >= 0; i--)
			shift(f[i]);
		level(0); // idle line falls to its pulldown level
	endtask : send
	// the serial clock always stands low here
	task automatic load(input logic b);
		o_sload <= b;
		repeat (gap) @(posedge i_clk);
	endtask : load
endmodule : synth_ctl_model

// *** sim/synth_cfg_top_tb.sv ***
// self-checking bench for synth_cfg_top over apb and its pins
// assumes synth_ctl_model drives the serial pins
module synth_cfg_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
		$display("unexpected at %0t: got %h want %h", $time, a, b); end end
	localparam logic [11:0] CTL = synth_pkg::CTRL_ADDR;
	localparam logic [11:0] STA = synth_pkg::STATUS_ADDR;
	localparam logic [11:0] SHF = synth_pkg::SHIFT_ADDR;
	localparam logic [32:0] ALL = 33'h1FFFFFFFF;
	logic clk, rst, mr, pstb_n, refsel, byp, xtal, alt, psel, penable, pwrite;
	logic mon, fbo, pready, pslverr, sclk, sdat, sld, ref_run, v;
	logic pfd, xo;
	logic [8:0] fbp, m, cm;
	logic [2:0] ncp, cn;
	logic [2:0] ck = 3'h0;
	logic [1:0] ct, tru, cmp;
	logic [11:0] paddr;
	logic [13:0] f;
	logic [31:0] pwdata, prdata, rnd;
	logic [65:0] ev, x;
	logic [65:0] q[$];
	int mismatches = 0, checked = 0, a, b, k;
	int hp[8] = '{2, 3, 4, 6, 8, 12, 16, 24}; // two clocks per vco ratio
	synth_cfg_top dut_u (.I_CLOCK(clk), .I_RST(rst), .I_MASTER_RESET_IN(mr),
		.I_PARALLEL_LOAD_STROBE_N(pstb_n), .I_SERIAL_CLOCK(sclk),
		.I_SERIAL_DATA(sdat), .I_SERIAL_LOAD(sld),
		.I_FEEDBACK_DIVIDE_BITS(fbp), .I_OUTPUT_DIVIDE_CODE(ncp),
		.I_REFERENCE_SOURCE_SELECT(refsel), .I_PLL_BYPASS_SELECT(byp),
		.I_CRYSTAL_OSC_INPUT(xtal), .I_ALT_REF_CLOCK(alt),
		.O_CRYSTAL_OSC_OUTPUT(xo), .O_CLOCK_OUT_TRUE(tru),
		.O_CLOCK_OUT_COMPLEMENT(cmp), .O_MONITOR(mon), .O_PFD_REF(pfd),
		.O_FB_DIV_OUT(fbo), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr));
	synth_ctl_model ctl_u (.i_clk(clk), .o_sclk(sclk), .o_sdata(sdat),
		.o_sload(sld));
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) if (ref_run) begin
		ck <= ck + 3'h1;
		xtal <= ck[1];
		alt <= ck[2];
	end
	always @(posedge clk) if (psel && penable && !pwrite && pready === 1'b1) begin
		ev = q.pop_front();
		`CHK({pslverr, prdata} & ev[32:0], ev[65:33])
	end
	initial begin
		repeat (60000) @(posedge clk);
		mismatches++;
		tally_and_finish();
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// bit 19 follows a free-running reference, so it is masked off
	function automatic logic [65:0] st(logic [8:0] fm, logic [2:0] fn,
		logic [1:0] ft, logic md, logic rn, logic pl);
		return {14'h0, pl, rn, md, 2'h0, ft, fn, fm, 33'h1FFF7FFFF};
	endfunction : st
	function automatic logic sig(input int s);
		return s == 2 ? pfd : (s == 1 ? fbo : tru[0]);
	endfunction : sig
	// outputs are looked at on the falling edge, where they are settled
	task automatic run(input int s, output int n);
		logic w;
		w = sig(s);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (sig(s) === w && n < 3000);
	endtask : run
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		int kk = 0;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk);
		while (pready !== 1'b1 && ++kk < 50);
		if (kk >= 50)
			mismatches++;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask : apb
	task automatic rd(input logic [11:0] ad, input logic [65:0] e);
		q.push_back(e);
		apb(0, ad, 32'h0);
	endtask : rd
	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		{rst, pstb_n, refsel, byp, ref_run, mr, xtal, alt} = 8'hF8;
		{psel, penable, pwrite} = 3'h0;
		fbp = synth_pkg::M_RST;
		ncp = synth_pkg::N_RST;
		paddr = 12'h000;
		pwdata = 32'h0;
		rnd = 32'h96A1BE43;
		repeat (10) @(posedge clk);
		rst <= 0;
		repeat (8) @(posedge clk);
		{ct, cn, cm} = {synth_pkg::T_RST, synth_pkg::N_RST, synth_pkg::M_RST};
		rd(CTL, {33'h0, ALL});
		apb(1, STA, 32'hFFFFFFFF);
		rd(STA, st(cm, cn, ct, 1, 1, 1));
		rd(12'h00C, {33'h100000000, ALL});
		for (int c = 0; c < 8; c++) begin
			rnd = lfsr(rnd);
			m = 9'(250 + rnd % 251);
			pstb_n <= 0;
			fbp <= m;
			ncp <= 3'(c);
			repeat (12) @(posedge clk);
			rd(STA, st(m, 3'(c), ct, 0, 1, 1));
			run(0, a);
			run(0, a);
			run(0, b);
			@(posedge clk);
			`CHK(a, hp[c])
			`CHK(b, hp[c])
		end
		run(1, a);
		run(1, a);
		`CHK(a, 2 * m)
		@(posedge clk);
		pstb_n <= 1;
		repeat (8) @(posedge clk);
		fbp <= ~m;
		ncp <= 3'h0;
		repeat (8) @(posedge clk);
		{cn, cm} = {3'h7, m};
		rd(STA, st(cm, cn, ct, 1, 1, 1));
		for (int t = 0; t < 4; t++) begin
			rnd = lfsr(rnd);
			f = {2'(t), rnd[11:9], 9'(250 + rnd % 251)};
			ctl_u.gap = t % 2 ? 9 : 4;
			ctl_u.send(f);
			fbp <= rnd[20:12];
			rd(SHF, {19'h0, f, ALL});
			rd(STA, st(cm, cn, ct, 1, 1, 1));
			ctl_u.load(1);
			ctl_u.load(0);
			{ct, cn, cm} = f;
			rd(STA, st(cm, cn, ct, 1, 1, 1));
			ctl_u.level(1);
			v = mon;
			k = 0;
			while (t > 1 && mon === v && k < 1200) begin
				@(posedge clk);
				k++;
			end
			`CHK(t > 1 ? mon !== v : v === 1'(t), 1'b1)
			ctl_u.level(0);
		end
		ctl_u.load(1);
		f = {2'h0, rnd[23:21], 9'(250 + rnd % 199)};
		ctl_u.send(f);
		{ct, cn, cm} = f;
		rd(STA, st(cm, cn, ct, 1, 1, 1));
		ctl_u.load(0);
		mr <= 1;
		repeat (10) @(posedge clk);
		rd(STA, st(cm, cn, ct, 1, 0, 1));
		apb(1, CTL, 32'h1);
		rd(CTL, {33'h1, ALL});
		apb(1, CTL, 32'h0);
		mr <= 0;
		repeat (10) @(posedge clk);
		rd(STA, st(cm, cn, ct, 1, 1, 1));
		// crystal ref period is 4 clocks, alternate 8; both edges tick bypass
		run(2, a);
		run(2, a);
		@(posedge clk);
		`CHK(a, 16 / 2 * 4)
		refsel <= 0;
		byp <= 0;
		repeat (8) @(posedge clk);
		run(2, a);
		run(2, a);
		run(0, b);
		run(0, b);
		@(posedge clk);
		`CHK(a, 16 / 2 * 8)
		`CHK(b, hp[cn] * 4)
		ref_run = 0;
		{xtal, alt} <= 2'b10;
		for (int i = 0; i < 4; i++) begin
			refsel <= i[0];
			byp <= i[1];
			repeat (8) @(posedge clk);
			x = st(cm, cn, ct, 1, 1, i[1]);
			{x[52], x[19]} = {i[0], 1'b1};
			rd(STA, x);
		end
		`CHK(xo, 1'b0)
		xtal <= 0;
		repeat (8) @(posedge clk);
		`CHK(xo, 1'b1)
		tally_and_finish();
	end
endmodule : synth_cfg_top_tb

bind synth_cfg_top synth_cfg_props props_u (.I_CLOCK(I_CLOCK), .I_RST(I_RST),
	.I_MASTER_RESET_IN(I_MASTER_RESET_IN),
	.I_PARALLEL_LOAD_STROBE_N(I_PARALLEL_LOAD_STROBE_N),
	.I_PLL_BYPASS_SELECT(I_PLL_BYPASS_SELECT), .I_PSEL(I_PSEL),
	.I_PENABLE(I_PENABLE), .I_PADDR(I_PADDR),
	.O_CLOCK_OUT_TRUE(O_CLOCK_OUT_TRUE),
	.O_CLOCK_OUT_COMPLEMENT(O_CLOCK_OUT_COMPLEMENT), .O_MONITOR(O_MONITOR),
	.O_PFD_REF(O_PFD_REF), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
	.O_PSLVERR(O_PSLVERR));
